// >>> pkg/two_wire_regs.vh
// Function
// - four modes: master/slave transmit/receive
// - direction bit high reads, low writes
// - acknowledge low, not-acknowledge high on data
// - each packet is eight bits plus acknowledge
// - bus held while transfer-done flag set, except after a slave-receive stop (0xA0)
// - flag set after byte and acknowledge sampled
// - flag+enable+stop request makes stop condition
// - status code posted with every flag set
// - data write while flag low discarded, collision
// - start sent sets flag, status 0x08
// - address direction selects master transmit/receive
// - stop request bit clears itself after stop
`ifndef TWO_WIRE_REGS_VH
`define TWO_WIRE_REGS_VH
// ==========================================
// status codes, prescaler bits zero
`define C_START 8'h08
`define C_RESTART 8'h10
`define C_TX_ADR_ACK 8'h18
`define C_TX_ADR_NACK 8'h20
`define C_TX_DAT_ACK 8'h28
`define C_TX_DAT_NACK 8'h30
`define C_ARB_LOST 8'h38
`define C_RX_ADR_ACK 8'h40
`define C_RX_ADR_NACK 8'h48
`define C_RX_DAT_ACK 8'h50
`define C_RX_DAT_NACK 8'h58
`define C_SRX_ADR_ACK 8'h60
`define C_SRX_DAT_ACK 8'h80
`define C_SRX_DAT_NACK 8'h88
`define C_SRX_STOP 8'hA0
`define C_STX_ADR_ACK 8'hA8
`define C_STX_DAT_ACK 8'hB8
`define C_STX_DAT_NACK 8'hC0
`define C_IDLE 8'hF8
`define STATUS_MASK 8'hF8
// ==========================================
// timing
`define QUARTER_NS 1250
`define QUARTER_CYC ((`QUARTER_NS + 9) / 10)
`define OWN_ADDR_RESET 7'h00
`endif

// >>> rtl/pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for the bus lines
module pin_sync (
    // clock
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    // async lines in, clean lines out
    input wire [1:0] async_in,
    output reg [1:0] sync_out
);
    reg [1:0] meta; // first stage, read only by sync_out

    // ==========================================
    // sync stages; lines idle high
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            meta <= 2'h3;
            sync_out <= 2'h3;
        end else if (ce) begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/two_wire_transfer_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_regs.vh"
// byte sequencer of the two-wire port, master and slave
module two_wire_transfer_sequencer #(
    parameter QUARTER = `QUARTER_CYC
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    input wire ce,
    // control writes: strobe with bits
    input wire ctrl_wr,
    input wire ctrl_done_wr,
    input wire ctrl_start,
    input wire ctrl_stop,
    input wire ctrl_ack_en,
    input wire ctrl_enable,
    // data register write
    input wire data_wr,
    input wire [7:0] data_wdata,
    // own slave address
    input wire [6:0] own_addr,
    // software view
    output reg done_flag,
    output reg write_collision_flag,
    output reg stop_req,
    output reg [7:0] status_register,
    output reg [7:0] data_register,
    output reg master_transmit_mode,
    output reg master_receive_mode,
    output reg slave_transmit_mode,
    output reg slave_receive_mode,
    // bus pins, output enable pulls low
    input wire scl_in,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_oe
);
    // states, one hot
    localparam S_IDLE = 7'h01;
    localparam S_START = 7'h02;
    localparam S_BIT = 7'h04;
    localparam S_WAIT = 7'h08;
    localparam S_STOP = 7'h10;
    localparam S_SLAVE = 7'h20;
    localparam S_SWAIT = 7'h40;

    wire [1:0] lines; // synchronised scl, sda
    reg [6:0] state;
    reg [15:0] tick; // quarter-bit timer
    reg [1:0] phase; // quarter of bit
    reg [3:0] bitn; // 0..7 data, 8 acknowledge
    reg [7:0] shreg;
    reg addr_phase; // current byte is the address packet
    reg enable;
    reg ack_en;
    reg start_req;
    reg scl_d, sda_d;
    reg ack_bit;

    pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .async_in({scl_in, sda_in}),
        .sync_out(lines)
    );

    wire scl_s = lines[1];
    wire sda_s = lines[0];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire bus_start = scl_s & sda_d & ~sda_s;
    wire bus_stop = scl_s & ~sda_d & sda_s;
    wire tick_end = (tick == QUARTER[15:0] - 16'h1);
    wire master = master_transmit_mode | master_receive_mode;
    wire sending = master_transmit_mode | slave_transmit_mode | (addr_phase & master);

    // post an event: set the flag and load the status code
    task post;
        input [7:0] code;
        begin
            done_flag <= 1'b1;
            status_register <= code;
        end
    endtask

    // ==========================================
    // main sequencer
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= S_IDLE;
            tick <= 16'h0;
            phase <= 2'h0;
            bitn <= 4'h0;
            shreg <= 8'h00;
            addr_phase <= 1'b0;
            enable <= 1'b0;
            ack_en <= 1'b0;
            start_req <= 1'b0;
            stop_req <= 1'b0;
            done_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            status_register <= `C_IDLE;
            data_register <= 8'h00;
            master_transmit_mode <= 1'b0;
            master_receive_mode <= 1'b0;
            slave_transmit_mode <= 1'b0;
            slave_receive_mode <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            ack_bit <= 1'b0;
        end else if (ce) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            // control write; writing one clears the flag
            if (ctrl_wr) begin
                enable <= ctrl_enable;
                ack_en <= ctrl_ack_en;
                start_req <= ctrl_start;
                stop_req <= ctrl_stop;
                if (ctrl_done_wr) begin
                    done_flag <= 1'b0;
                    write_collision_flag <= 1'b0;
                end
            end
            // data write only while flag set; after the clear so a collision wins
            if (data_wr) begin
                if (done_flag) begin
                    data_register <= data_wdata;
                end else begin
                    write_collision_flag <= 1'b1;
                end
            end
            tick <= tick_end ? 16'h0 : tick + 16'h1;
            case (state)
                // idle: wait for a start request or a bus start
                S_IDLE: begin
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    if (enable && !done_flag && start_req && scl_s && sda_s) begin
                        state <= S_START;
                        phase <= 2'h0;
                        tick <= 16'h0;
                    end else if (enable && bus_start) begin
                        state <= S_SLAVE;
                        bitn <= 4'h0;
                        addr_phase <= 1'b1;
                    end
                end
                // start or repeated start: sda falls while scl high
                S_START: begin
                    if (tick_end) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: begin
                                sda_oe <= 1'b0;
                            end
                            2'h1: begin
                                scl_oe <= 1'b0;
                            end
                            2'h2: begin
                                sda_oe <= 1'b1;
                            end
                            default: begin
                                scl_oe <= 1'b1;
                                start_req <= 1'b0;
                                post(master ? `C_RESTART : `C_START);
                                master_transmit_mode <= 1'b1;
                                addr_phase <= 1'b1;
                                state <= S_WAIT;
                            end
                        endcase
                    end
                end
                // master bit clock: 4 quarters per bit, 9 bits a packet
                S_BIT: begin
                    if (tick_end) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: begin
                                if (bitn == 4'h8) begin
                                    // acknowledge slot; receiver drives low
                                    sda_oe <= sending ? 1'b0 : ack_en;
                                end else begin
                                    sda_oe <= sending ? ~shreg[7] : 1'b0;
                                end
                            end
                            2'h1: begin
                                scl_oe <= 1'b0;
                            end
                            2'h2: begin
                                if (bitn == 4'h8) begin
                                    ack_bit <= ~sda_s;
                                end else begin
                                    shreg <= {shreg[6:0], sda_s};
                                end
                            end
                            default: begin
                                scl_oe <= 1'b1;
                                if (bitn == 4'h8) begin
                                    state <= S_WAIT;
                                    if (addr_phase) begin
                                        addr_phase <= 1'b0;
                                        master_receive_mode <= data_register[0];
                                        master_transmit_mode <= ~data_register[0];
                                        if (data_register[0]) begin
                                            post(ack_bit ? `C_RX_ADR_ACK : `C_RX_ADR_NACK);
                                        end else begin
                                            post(ack_bit ? `C_TX_ADR_ACK : `C_TX_ADR_NACK);
                                        end
                                    end else if (master_transmit_mode) begin
                                        post(ack_bit ? `C_TX_DAT_ACK : `C_TX_DAT_NACK);
                                    end else begin
                                        data_register <= shreg;
                                        post(ack_en ? `C_RX_DAT_ACK : `C_RX_DAT_NACK);
                                    end
                                end else begin
                                    bitn <= bitn + 4'h1;
                                end
                            end
                        endcase
                    end
                end
                // hold scl low until software clears the flag
                S_WAIT: begin
                    if (!done_flag && !ctrl_wr) begin
                        phase <= 2'h0;
                        tick <= 16'h0;
                        bitn <= 4'h0;
                        shreg <= data_register;
                        if (!enable) begin
                            state <= S_IDLE;
                        end else if (stop_req) begin
                            state <= S_STOP;
                        end else if (start_req) begin
                            state <= S_START;
                            sda_oe <= 1'b0;
                        end else begin
                            state <= S_BIT;
                        end
                    end
                end
                // stop: sda rises while scl high
                S_STOP: begin
                    if (tick_end) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: begin
                                sda_oe <= 1'b1;
                            end
                            2'h1: begin
                                scl_oe <= 1'b0;
                            end
                            2'h2: begin
                                sda_oe <= 1'b0;
                            end
                            default: begin
                                stop_req <= 1'b0;
                                master_transmit_mode <= 1'b0;
                                master_receive_mode <= 1'b0;
                                status_register <= `C_IDLE;
                                state <= S_IDLE;
                            end
                        endcase
                    end
                end
                // slave: shift on scl edges
                S_SLAVE: begin
                    if (bus_stop) begin
                        sda_oe <= 1'b0;
                        state <= S_IDLE;
                        if (slave_receive_mode) begin
                            post(`C_SRX_STOP);
                        end
                        slave_receive_mode <= 1'b0;
                        slave_transmit_mode <= 1'b0;
                    end else if (scl_rise) begin
                        if (bitn == 4'h8) begin
                            ack_bit <= ~sda_s;
                        end else begin
                            shreg <= {shreg[6:0], sda_s};
                        end
                    end else if (scl_fall) begin
                        if (bitn == 4'h7 && addr_phase) begin
                            // address matched and acknowledge enabled
                            sda_oe <= ack_en && shreg[7:1] == own_addr;
                            bitn <= 4'h8;
                        end else if (bitn == 4'h7) begin
                            sda_oe <= slave_receive_mode & ack_en;
                            bitn <= 4'h8;
                        end else if (bitn == 4'h8) begin
                            sda_oe <= 1'b0;
                            bitn <= 4'h0;
                            if (addr_phase) begin
                                addr_phase <= 1'b0;
                                if (sda_oe) begin
                                    slave_transmit_mode <= shreg[0];
                                    slave_receive_mode <= ~shreg[0];
                                    scl_oe <= 1'b1;
                                    state <= S_SWAIT;
                                    post(shreg[0] ? `C_STX_ADR_ACK : `C_SRX_ADR_ACK);
                                end else begin
                                    state <= S_IDLE;
                                end
                            end else begin
                                scl_oe <= 1'b1;
                                state <= S_SWAIT;
                                if (slave_receive_mode) begin
                                    data_register <= shreg;
                                    post(ack_en ? `C_SRX_DAT_ACK : `C_SRX_DAT_NACK);
                                end else begin
                                    post(ack_bit ? `C_STX_DAT_ACK : `C_STX_DAT_NACK);
                                end
                            end
                        end else begin
                            bitn <= bitn + 4'h1;
                            if (slave_transmit_mode) begin
                                sda_oe <= ~shreg[6];
                                shreg <= {shreg[6:0], 1'b0};
                            end
                        end
                    end
                end
                // slave stretches scl until flag cleared
                S_SWAIT: begin
                    if (!done_flag && !ctrl_wr) begin
                        scl_oe <= 1'b0;
                        state <= S_SLAVE;
                        if (slave_transmit_mode) begin
                            shreg <= {data_register[6:0], 1'b0};
                            sda_oe <= ~data_register[7];
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> sim/bus_target_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bus target: acks its address, takes and gives bytes
module bus_target_model #(parameter logic [6:0] ADDR = 7'h55) (
    // wire levels
    input wire logic scl,
    input wire logic sda,
    // scenario controls
    input wire logic nack_next,
    input wire logic [7:0] rd_byte,
    // pull on data, last byte taken
    output logic sda_pull,
    output logic [7:0] got_byte
);
    logic active = 1'b0; // inside a transfer addressed to us
    logic is_addr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] bitc = 4'h0;
    logic [7:0] sh = 8'h00;
    initial sda_pull = 1'b0;
    initial got_byte = 8'h00;
    // start and stop: data moves while the clock is high
    always @(sda) begin
        if (scl === 1'b1) begin
            active = !sda;
            is_addr = 1'b1;
            bitc = 4'h0;
            sda_pull = 1'b0;
        end
    end
    // bits are taken on the rising clock, msb first
    always @(posedge scl) begin
        if (active) begin
            if (bitc < 4'h8) sh = {sh[6:0], sda};
            else if (rd && !is_addr && sda) active = 1'b0;
            bitc = bitc + 4'h1;
        end
    end
    // data changes only while the clock is low; released lines float high
    always @(negedge scl) begin
        if (active) begin
            if (bitc == 4'h9) begin
                bitc = 4'h0;
                is_addr = 1'b0;
            end
            if (bitc == 4'h8 && is_addr) begin
                rd = sh[0];
                active = (sh[7:1] == ADDR);
                sda_pull = active;
            end else if (bitc == 4'h8) begin
                if (!rd) got_byte = sh;
                sda_pull = !rd && !nack_next;
            end else begin
                sda_pull = rd && !is_addr && !rd_byte[3'h7 - bitc[2:0]];
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/test_two_wire_transfer_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_regs.vh"
module test_two_wire_transfer_sequencer;
    // ==========================================
    // stimulus, wires and bookkeeping
    localparam int Q = 4; // short quarter keeps the bus clock at 160 ns
    localparam logic [6:0] PEER = 7'h55;
    logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, ctrl_wr = 1'b0, ctrl_done_wr = 1'b0;
    logic ctrl_start = 1'b0, ctrl_stop = 1'b0, ctrl_ack_en = 1'b0, ctrl_enable = 1'b0;
    logic data_wr = 1'b0, nack_next = 1'b0, prev_done = 1'b0;
    logic [7:0] data_wdata = 8'h00, rd_byte = 8'h00, b;
    logic [7:0] exp_q[$]; // expected status codes
    wire done_flag, write_collision_flag, stop_req, scl_oe, sda_oe, sda_pull;
    wire mtx, mrx, stx, srx;
    wire [7:0] status_register, data_register, got_byte;
    wire scl = ~scl_oe; // open drain with pull-ups
    wire sda = ~(sda_oe | sda_pull);
    int n_errors = 0, checked = 0, cycles = 0, seed, r;
    two_wire_transfer_sequencer #(.QUARTER(Q)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .ctrl_wr(ctrl_wr), .ctrl_done_wr(ctrl_done_wr),
        .ctrl_start(ctrl_start), .ctrl_stop(ctrl_stop), .ctrl_ack_en(ctrl_ack_en),
        .ctrl_enable(ctrl_enable), .data_wr(data_wr), .data_wdata(data_wdata), .own_addr(7'h12),
        .done_flag(done_flag), .write_collision_flag(write_collision_flag), .stop_req(stop_req),
        .status_register(status_register), .data_register(data_register),
        .master_transmit_mode(mtx), .master_receive_mode(mrx),
        .slave_transmit_mode(stx), .slave_receive_mode(srx),
        .scl_in(scl), .scl_oe(scl_oe), .sda_in(sda), .sda_oe(sda_oe));
    bus_target_model #(.ADDR(PEER)) peer (.scl(scl), .sda(sda), .nack_next(nack_next),
        .rd_byte(rd_byte), .sda_pull(sda_pull), .got_byte(got_byte));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // ==========================================
    // shared tasks
    task automatic fail(input string msg);
        n_errors++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
    endtask
    task automatic give_verdict;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // control write: flag clear and enable set
    task automatic ctrl(input logic s, input logic p, input logic a);
        @(negedge clk_sys);
        {ctrl_wr, ctrl_done_wr, ctrl_enable} = 3'h7;
        {ctrl_start, ctrl_stop, ctrl_ack_en} = {s, p, a};
        @(negedge clk_sys);
        ctrl_wr = 1'b0;
    endtask
    task automatic wdata(input logic [7:0] v);
        @(negedge clk_sys);
        data_wr = 1'b1;
        data_wdata = v;
        @(negedge clk_sys);
        data_wr = 1'b0;
    endtask
    // bounded poll
    task automatic wait_for(input logic want_done);
        int i = 0;
        while ((want_done ? done_flag : stop_req) !== want_done && i < 400) begin
            @(negedge clk_sys);
            i++;
        end
        if (i >= 400) fail("wait ran out");
    endtask
    task automatic start();
        exp_q.push_back(`C_START);
        ctrl(1'b1, 1'b0, 1'b0);
        wait_for(1'b1);
    endtask
    task automatic xfer(input logic [7:0] v, input logic a, input logic [7:0] code);
        exp_q.push_back(code);
        wdata(v);
        ctrl(1'b0, 1'b0, a);
        wait_for(1'b1);
    endtask
    task automatic stop();
        ctrl(1'b0, 1'b1, 1'b0);
        wait_for(1'b0);
        chk(status_register, `C_IDLE);
    endtask
    // ==========================================
    // watcher: each rising flag takes the oldest code
    always @(negedge clk_sys) begin
        if (done_flag === 1'b1 && prev_done !== 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected completion");
            else chk(status_register & `STATUS_MASK, exp_q.pop_front());
        end
        prev_done <= done_flag;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 10000) begin
            fail("timeout");
            give_verdict();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        seed = 38;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk(status_register, `C_IDLE);
        wdata(8'h3C);
        chk({7'h00, write_collision_flag}, 8'h01);
        start();
        chk({7'h00, write_collision_flag}, 8'h00);
        xfer({PEER, 1'b0}, 1'b0, `C_TX_ADR_ACK);
        chk({4'h0, mtx, mrx, stx, srx}, 8'h08);
        r = $random(seed);
        b = r[7:0];
        xfer(b, 1'b0, `C_TX_DAT_ACK);
        chk(got_byte, b);
        nack_next = 1'b1;
        xfer(~b, 1'b0, `C_TX_DAT_NACK);
        chk(got_byte, ~b);
        nack_next = 1'b0;
        stop();
        start();
        xfer({PEER ^ 7'h01, 1'b0}, 1'b0, `C_TX_ADR_NACK);
        stop();
        r = $random(seed);
        rd_byte = r[7:0];
        start();
        xfer({PEER, 1'b1}, 1'b0, `C_RX_ADR_ACK);
        chk({4'h0, mtx, mrx, stx, srx}, 8'h04);
        xfer(8'hFF, 1'b1, `C_RX_DAT_ACK);
        chk(data_register, rd_byte);
        xfer(8'hFF, 1'b0, `C_RX_DAT_NACK);
        chk(data_register, rd_byte);
        stop();
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> sim/two_wire_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_regs.vh"
// ==========================================
// port-level checks of the byte sequencer
module two_wire_seq_sva #(parameter int QUARTER = 4) (
    // clock and reset
    input wire logic clk_sys, input wire logic rst_n, input wire logic ce,
    // control and data writes
    input wire logic ctrl_wr, input wire logic ctrl_done_wr, input wire logic ctrl_start,
    input wire logic ctrl_stop, input wire logic ctrl_enable, input wire logic data_wr,
    // software view
    input wire logic done_flag, input wire logic write_collision_flag,
    input wire logic stop_req, input wire logic [7:0] status_register,
    input wire logic master_transmit_mode, input wire logic master_receive_mode,
    input wire logic slave_transmit_mode, input wire logic slave_receive_mode,
    // bus pins
    input wire logic scl_oe, input wire logic sda_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // bounds with slack for the two-flop line synchroniser
    localparam int START_MAX = 5 * QUARTER + 8;
    localparam int STOP_MAX = 8 * QUARTER + 8;
    localparam int PKT_MIN = 35 * QUARTER;
    localparam int PKT_MAX = 37 * QUARTER;
    logic [15:0] pkt_cnt; // cycles since a plain clear of the flag
    logic pkt_on;
    // ==========================================
    // packet timer, restarted by a plain clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pkt_on <= 1'b0;
            pkt_cnt <= 16'h0000;
        end else if (ce && ctrl_wr && ctrl_done_wr && done_flag && !ctrl_start && !ctrl_stop) begin
            pkt_on <= 1'b1;
            pkt_cnt <= 16'h0000;
        end else if (done_flag) begin
            pkt_on <= 1'b0;
        end else if (ce) begin
            pkt_cnt <= pkt_cnt + 16'h0001;
        end
    end
    sequence s_start_req;
        ce && ctrl_wr && ctrl_done_wr && ctrl_start && ctrl_enable && !done_flag;
    endsequence
    sequence s_start_done;
        ##[1:START_MAX] (done_flag && status_register == `C_START);
    endsequence
    sequence s_stop_req;
        ce && ctrl_wr && ctrl_done_wr && ctrl_stop && ctrl_enable && !ctrl_start && done_flag;
    endsequence
    sequence s_stop_done;
        stop_req ##[1:STOP_MAX] !stop_req;
    endsequence
    property p_coll;
        ce && data_wr && !done_flag |=> write_collision_flag;
    endproperty
    a_coll: assert property (p_coll) else $error("collision flag not set");
    property p_coll_cause;
        $rose(write_collision_flag) |-> $past(data_wr) && !$past(done_flag);
    endproperty
    a_coll_cause: assert property (p_coll_cause) else $error("collision without cause");
    property p_hold;
        done_flag && !(ctrl_wr && ctrl_done_wr) |=> done_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped by itself");
    property p_frozen;
        done_flag && $past(done_flag) && !ctrl_wr |=> $stable(scl_oe) && $stable(sda_oe);
    endproperty
    a_frozen: assert property (p_frozen) else $error("bus moved while held");
    property p_code;
        $rose(done_flag) |-> status_register[2:0] == 3'h0 && status_register != `C_IDLE;
    endproperty
    a_code: assert property (p_code) else $error("no event code with flag");
    property p_start;
        s_start_req |-> s_start_done;
    endproperty
    a_start: assert property (p_start) else $error("start not reported");
    property p_pkt;
        $rose(done_flag) && pkt_on |-> pkt_cnt >= PKT_MIN && pkt_cnt <= PKT_MAX;
    endproperty
    a_pkt: assert property (p_pkt) else $error("packet length wrong");
    property p_txmode;
        $rose(done_flag) && status_register == `C_TX_ADR_ACK |-> master_transmit_mode;
    endproperty
    a_txmode: assert property (p_txmode) else $error("transmit mode not entered");
    property p_modes;
        $onehot0({master_transmit_mode, master_receive_mode, slave_transmit_mode,
                  slave_receive_mode});
    endproperty
    a_modes: assert property (p_modes) else $error("two modes at once");
    property p_stop;
        s_stop_req |=> s_stop_done;
    endproperty
    a_stop: assert property (p_stop) else $error("stop request not served");
    property p_stop_idle;
        $fell(stop_req) |-> status_register == `C_IDLE && !scl_oe && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
endmodule
bind two_wire_transfer_sequencer two_wire_seq_sva #(.QUARTER(QUARTER)) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .ctrl_wr(ctrl_wr), .ctrl_done_wr(ctrl_done_wr),
    .ctrl_start(ctrl_start), .ctrl_stop(ctrl_stop), .ctrl_enable(ctrl_enable), .data_wr(data_wr),
    .done_flag(done_flag), .write_collision_flag(write_collision_flag), .stop_req(stop_req),
    .status_register(status_register), .master_transmit_mode(master_transmit_mode),
    .master_receive_mode(master_receive_mode), .slave_transmit_mode(slave_transmit_mode),
    .slave_receive_mode(slave_receive_mode), .scl_oe(scl_oe), .sda_oe(sda_oe));
`default_nettype wire
